//--- hdl/cfg_bank_pkg.sv
package cfg_bank_pkg;

    // --------------------------------------------------------------
    // Register space geometry
    // --------------------------------------------------------------
    localparam int           SPACE_AW      = 15;           // 32k-byte user space
    localparam int           OFFSET_W      = 8;            // 256 registers per page
    localparam int           PAGE_W        = 8;
    localparam logic [7:0]   PAGE_FIRST    = 8'hC0;
    localparam logic [7:0]   PAGE_LAST     = 8'hCF;
    localparam int           MODULE_AW     = 4;            // 16 bytes per module
    localparam logic [3:0]   TRIGGER_OFS   = 4'hF;         // Highest byte of a module

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [7:0]   DEFAULT_BYTE  = 8'h00;
    localparam logic [7:0]   PAGE_RESET    = 8'hC0;
    localparam logic [14:0]  SPACE_LAST    = 15'h7FFF;
    localparam logic [14:0]  ADDR_ZERO     = 15'h0000;

    // --------------------------------------------------------------
    // Carriers and states
    // --------------------------------------------------------------
    typedef struct packed {
        logic [SPACE_AW-1:0] addr;
        logic [7:0]          data;
    } cfg_beat_t;

    typedef enum logic [2:0] {
        S_CLEAR,
        S_OTP,
        S_OTP_APPLY,
        S_EE,
        S_EE_APPLY,
        S_IDLE,
        S_MOD_APPLY
    } bank_state_t;

endpackage

//--- hdl/paged_cfg_bank.sv
`timescale 1ns/1ps
// Functional notes
// - Host reaches a 32k-byte configuration register space.
// - Every register leaves reset holding its default value.
// - Values come from factory OTP, external EEPROM or host serial writes.
// - Map holds 128 pages, 0x80 to 0xFF, each of 256 byte registers.
// - An 8-bit in-page offset selects exactly one register of the page.
// - Host sets page first, then offset; target is page plus offset.
// - Module writes stay pending until the module trigger is written.
// - Trigger write commits even when its value is unchanged.
// - Trigger sits at the highest address of its module.
// - Defaults load first, then OTP, then EEPROM, each applied in one sweep, before host writes.
module paged_cfg_bank
(
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    // OTP load stream
    input  wire logic                        otp_valid,
    input  wire cfg_bank_pkg::cfg_beat_t     otp_beat,
    input  wire logic                        otp_done,
    // EEPROM load stream
    input  wire logic                        ee_valid,
    input  wire cfg_bank_pkg::cfg_beat_t     ee_beat,
    input  wire logic                        ee_done,
    // Host serial access
    input  wire logic                        host_page_wr,
    input  wire logic [7:0]                  host_page,
    input  wire logic                        host_wr,
    input  wire logic                        host_rd,
    input  wire logic [7:0]                  host_offset,
    input  wire logic [7:0]                  host_wdata,
    output logic                             host_ready,
    output logic                             host_rd_valid,
    output logic [7:0]                       host_rd_data,
    output logic [7:0]                       page,
    // Active configuration readout
    input  wire logic [14:0]                 cfg_rd_addr,
    output logic [7:0]                       cfg_rd_data,
    output logic                             load_done
);
    import cfg_bank_pkg::*;

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [SPACE_AW-1:0] space_index(input logic [7:0] pg, input logic [7:0] ofs);
        space_index = {pg[6:0], ofs};
    endfunction

    function automatic logic page_ok(input logic [7:0] pg);
        page_ok = pg[7];
    endfunction

    function automatic logic [SPACE_AW-1:0] module_base(input logic [SPACE_AW-1:0] a);
        module_base = {a[SPACE_AW-1:MODULE_AW], {MODULE_AW{1'b0}}};
    endfunction

    // --------------------------------------------------------------
    // Storage
    // --------------------------------------------------------------
    logic [7:0]          pending [0:(1<<SPACE_AW)-1];
    logic [7:0]          active  [0:(1<<SPACE_AW)-1];

    bank_state_t         state;
    bank_state_t         next_state;
    logic [SPACE_AW-1:0] cnt;
    logic [SPACE_AW-1:0] next_cnt;
    logic [SPACE_AW-1:0] last;
    logic [SPACE_AW-1:0] next_last;
    logic [7:0]          next_page;
    logic                next_host_ready;
    logic                next_host_rd_valid;
    logic [7:0]          next_host_rd_data;
    logic                next_load_done;

    logic                pend_we;
    logic [SPACE_AW-1:0] pend_addr;
    logic [7:0]          pend_data;
    logic                act_we;
    logic [SPACE_AW-1:0] act_addr;
    logic [7:0]          act_data;
    logic [SPACE_AW-1:0] host_addr;

    assign host_addr = space_index(page, host_offset);

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    always_comb
    begin
        next_state         = state;
        next_cnt           = cnt;
        next_last          = last;
        next_page          = page;
        next_host_rd_valid = 1'b0;
        next_host_rd_data  = host_rd_data;
        next_load_done     = load_done;
        pend_we            = 1'b0;
        pend_addr          = cnt;
        pend_data          = DEFAULT_BYTE;
        act_we             = 1'b0;
        act_addr           = cnt;
        act_data           = DEFAULT_BYTE;

        if (host_page_wr)
        begin
            next_page = host_page;
        end

        case (state)
            S_CLEAR:
            begin
                pend_we  = 1'b1;
                act_we   = 1'b1;
                next_cnt = cnt + 15'h0001;
                if (cnt == SPACE_LAST)
                begin
                    next_cnt   = ADDR_ZERO;
                    next_state = S_OTP;
                end
            end
            S_OTP:
            begin
                if (otp_valid)
                begin
                    pend_we   = 1'b1;
                    pend_addr = otp_beat.addr;
                    pend_data = otp_beat.data;
                end
                if (otp_done)
                begin
                    next_cnt   = ADDR_ZERO;
                    next_last  = SPACE_LAST;
                    next_state = S_OTP_APPLY;
                end
            end
            S_EE:
            begin
                if (ee_valid)
                begin
                    pend_we   = 1'b1;
                    pend_addr = ee_beat.addr;
                    pend_data = ee_beat.data;
                end
                if (ee_done)
                begin
                    next_cnt   = ADDR_ZERO;
                    next_last  = SPACE_LAST;
                    next_state = S_EE_APPLY;
                end
            end
            S_OTP_APPLY, S_EE_APPLY, S_MOD_APPLY:
            begin
                act_we   = 1'b1;
                act_data = pending[cnt];
                next_cnt = cnt + 15'h0001;
                if (cnt == last)
                begin
                    next_cnt = ADDR_ZERO;
                    case (state)
                        S_OTP_APPLY: next_state = S_EE;
                        default:     next_state = S_IDLE;
                    endcase
                end
            end
            S_IDLE:
            begin
                if (host_wr && page_ok(page))
                begin
                    pend_we   = 1'b1;
                    pend_addr = host_addr;
                    pend_data = host_wdata;
                    if (host_offset[MODULE_AW-1:0] == TRIGGER_OFS)
                    begin
                        next_cnt   = module_base(host_addr);
                        next_last  = host_addr;
                        next_state = S_MOD_APPLY;
                    end
                end
                else if (host_rd)
                begin
                    next_host_rd_valid = 1'b1;
                    next_host_rd_data  = page_ok(page) ? active[host_addr] : DEFAULT_BYTE;
                end
            end
            default:
            begin
                next_state = S_CLEAR;
                next_cnt   = ADDR_ZERO;
            end
        endcase

        next_host_ready = (next_state == S_IDLE);
        // Rises together with the first host_ready
        next_load_done  = load_done | (next_state == S_IDLE);
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state         <= S_CLEAR;
            cnt           <= ADDR_ZERO;
            last          <= SPACE_LAST;
            page          <= PAGE_RESET;
            host_ready    <= 1'b0;
            host_rd_valid <= 1'b0;
            host_rd_data  <= DEFAULT_BYTE;
            load_done     <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            cnt           <= next_cnt;
            last          <= next_last;
            page          <= next_page;
            host_ready    <= next_host_ready;
            host_rd_valid <= next_host_rd_valid;
            host_rd_data  <= next_host_rd_data;
            load_done     <= next_load_done;
        end
    end

    // --------------------------------------------------------------
    // Arrays and readout
    // --------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (pend_we)
        begin
            pending[pend_addr] <= pend_data;
        end
        if (act_we)
        begin
            active[act_addr] <= act_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_rd_data <= DEFAULT_BYTE;
        end
        else
        begin
            cfg_rd_data <= active[cfg_rd_addr];
        end
    end

endmodule // paged_cfg_bank

//--- dv/cfg_bank_assertions.sv
`timescale 1ns/1ps
// ----
// Host port checks
// ----
module cfg_bank_checker
(
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic       host_page_wr,
    input wire logic [7:0] host_page,
    input wire logic       host_wr,
    input wire logic       host_rd,
    input wire logic [7:0] host_offset,
    input wire logic       host_ready,
    input wire logic       host_rd_valid,
    input wire logic [7:0] page,
    input wire logic       load_done
);
    import cfg_bank_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    logic wr_ok;
    assign wr_ok = host_ready && host_wr && page[7];
    sequence s_busy;
        !host_ready [*8] ##1 !host_ready [*8];
    endsequence
    sequence s_back;
        host_ready;
    endsequence
    property p_trig_commit;
        wr_ok && host_offset[3:0] == TRIGGER_OFS |=> s_busy ##1 s_back;
    endproperty
    property p_plain_wr;
        wr_ok && host_offset[3:0] != TRIGGER_OFS |=> host_ready;
    endproperty
    property p_rd_answer;
        host_ready && host_rd && !host_wr |=> host_rd_valid;
    endproperty
    property p_rd_cause;
        host_rd_valid |-> $past(host_rd) && $past(host_ready);
    endproperty
    property p_page_load;
        host_page_wr |=> page == $past(host_page);
    endproperty
    property p_page_keep;
        !host_page_wr |=> page == $past(page);
    endproperty
    property p_done_keep;
        load_done |=> load_done;
    endproperty
    property p_idle_first;
        !load_done |-> !host_ready;
    endproperty
    property p_rst_vals;
        disable iff (1'b0) !rst_b |=> rst_b || (page == PAGE_RESET && !host_ready && !load_done);
    endproperty
    a_trig_commit: assert property (p_trig_commit) else $error("trigger busy window wrong");
    a_plain_wr: assert property (p_plain_wr) else $error("plain write stalled");
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    a_rd_cause: assert property (p_rd_cause) else $error("read answer without read");
    a_page_load: assert property (p_page_load) else $error("page not loaded");
    a_page_keep: assert property (p_page_keep) else $error("page changed alone");
    a_done_keep: assert property (p_done_keep) else $error("load done dropped");
    a_idle_first: assert property (p_idle_first) else $error("host served before load");
    a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
endmodule // cfg_bank_checker

bind paged_cfg_bank cfg_bank_checker chk (.mclk, .rst_b, .host_page_wr, .host_page, .host_wr, .host_rd,
    .host_offset, .host_ready, .host_rd_valid, .page, .load_done);

//--- dv/image_feeder.sv
`timescale 1ns/1ps
// ----
// OTP and EEPROM image source
// ----
module image_feeder
(
    input  wire logic                mclk,
    input  wire logic                rst_b,
    output logic                     otp_valid,
    output cfg_bank_pkg::cfg_beat_t  otp_beat,
    output logic                     otp_done,
    output logic                     ee_valid,
    output cfg_bank_pkg::cfg_beat_t  ee_beat,
    output logic                     ee_done
);
    import cfg_bank_pkg::*;
    logic [16:0] cnt;
    // Beats placed inside each load phase, except the first OTP beat, which falls in the clear phase; idle beats toggle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt <= '0;
            otp_valid <= 1'b0;
            otp_done <= 1'b0;
            ee_valid <= 1'b0;
            ee_done <= 1'b0;
            otp_beat <= '0;
            ee_beat <= '0;
        end
        else
        begin
            cnt <= cnt + 17'h1;
            otp_valid <= cnt == 17'h00100 || cnt == 17'h08100 || cnt == 17'h08101;
            otp_done <= cnt == 17'h08102;
            ee_valid <= cnt == 17'h10200;
            ee_done <= cnt == 17'h10201;
            // Beat at 0x00100 falls in the clear phase and must be ignored
            otp_beat <= cnt == 17'h00100 ? {15'h4005, 8'h77} : cnt == 17'h08100 ? {15'h4003, 8'hA5} :
                        cnt == 17'h08101 ? {15'h4004, 8'h5A} : ~otp_beat;
            ee_beat <= cnt == 17'h10200 ? {15'h4004, 8'h3C} : ~ee_beat;
        end
    end
endmodule // image_feeder

//--- dv/paged_config_register_bank_tb.sv
`timescale 1ns/1ps
module paged_config_register_bank_tb;
    import cfg_bank_pkg::*;
    logic        mclk, rst_b, otp_valid, otp_done, ee_valid, ee_done, host_page_wr, host_wr, host_rd;
    logic        host_ready, host_rd_valid, load_done;
    cfg_beat_t   otp_beat, ee_beat;
    logic [7:0]  host_page, host_offset, host_wdata, host_rd_data, page, cfg_rd_data;
    logic [14:0] cfg_rd_addr;
    int          err_total, checks_done;
    paged_cfg_bank dut (.mclk, .rst_b, .otp_valid, .otp_beat, .otp_done, .ee_valid, .ee_beat, .ee_done,
        .host_page_wr, .host_page, .host_wr, .host_rd, .host_offset, .host_wdata, .host_ready,
        .host_rd_valid, .host_rd_data, .page, .cfg_rd_addr, .cfg_rd_data, .load_done);
    image_feeder feeder (.mclk, .rst_b, .otp_valid, .otp_beat, .otp_done, .ee_valid, .ee_beat, .ee_done);
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wait_ready(input int lim);
        int n;
        n = 0;
        while (host_ready !== 1'b1 && n < lim)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (host_ready !== 1'b1)
        begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic set_page(input logic [7:0] p);
        @(posedge mclk);
        host_page_wr <= 1'b1;
        host_page <= p;
        @(posedge mclk);
        host_page_wr <= 1'b0;
    endtask
    task automatic host_write(input logic [7:0] ofs, input logic [7:0] d);
        @(posedge mclk);
        host_wr <= 1'b1;
        host_offset <= ofs;
        host_wdata <= d;
        @(posedge mclk);
        host_wr <= 1'b0;
        #1;
        wait_ready(40);
    endtask
    task automatic host_read(input logic [7:0] ofs, input logic [7:0] exp);
        @(posedge mclk);
        host_rd <= 1'b1;
        host_offset <= ofs;
        @(posedge mclk);
        host_rd <= 1'b0;
        #1;
        cmp8("rd_valid", 8'h01, {7'h0, host_rd_valid});
        cmp8("rd_data", exp, host_rd_data);
    endtask
    task automatic cfg_peek(input logic [14:0] a, input logic [7:0] exp);
        @(posedge mclk);
        cfg_rd_addr <= a;
        @(posedge mclk);
        #1;
        cmp8("cfg_rd", exp, cfg_rd_data);
    endtask
    task automatic t_load();
        wait_ready(100000);
        cmp8("load_done", 8'h01, {7'h0, load_done});
        cfg_peek(15'h4003, 8'hA5);
        cfg_peek(15'h4005, 8'h00);
        cfg_peek(15'h4004, 8'h3C);
        cfg_peek(15'h7FFF, 8'h00);
    endtask
    task automatic t_pending();
        set_page(8'hC1);
        host_write(8'h20, 8'h77);
        host_read(8'h20, 8'h00);
        cmp8("page", 8'hC1, page);
        host_write(8'h2F, 8'h00);
        host_read(8'h20, 8'h77);
        cfg_peek(15'h4120, 8'h77);
    endtask
    task automatic t_edges();
        set_page(8'hCF);
        host_write(8'hFE, 8'h11);
        host_write(8'hFF, 8'h22);
        cfg_peek(15'h4FFE, 8'h11);
        cfg_peek(15'h4FFF, 8'h22);
        set_page(8'hC0);
        host_read(8'h03, 8'hA5);
        // Page outside the map: write must not land at the aliased index
        set_page(8'h40);
        host_write(8'h2F, 8'h99);
        host_read(8'h2F, 8'h00);
        set_page(8'hC0);
        host_read(8'h2F, 8'h00);
    endtask
    initial
    begin
        rst_b = 1'b0;
        {host_page_wr, host_wr, host_rd} = 3'h0;
        {host_page, host_offset, host_wdata} = 24'h0;
        cfg_rd_addr = 15'h0;
        err_total = 0;
        checks_done = 0;
        repeat (16) @(posedge mclk);
        #1;
        cmp8("reset page", 8'hC0, page);
        cmp8("reset ready", 8'h00, {7'h0, host_ready});
        @(posedge mclk);
        rst_b <= 1'b1;
        t_load();
        t_pending();
        t_edges();
        tally_and_finish();
    end
endmodule // paged_config_register_bank_tb
